// *** inc/sram_port_pkg.sv ***
// =====================================================================
// sram_port_pkg: shared constants of the burst-of-four common-I/O port
// =====================================================================
// assumes: every user writes sram_port_pkg::name, nothing is imported
package sram_port_pkg;

  // =====================================================================
  // data path geometry
  // =====================================================================
  localparam int DATA_W = 36;          // wide configuration, all lines used
  localparam int NARROW_W = 18;        // narrow configuration, low lines only
  localparam int BYTE_W = 9;           // one byte-write mask line per 9 bits
  localparam int ADDR_W = 17;          // burst address width
  localparam int ARRAY_AW = 6;         // flop array index width (beat in low bits)
  localparam int BURST_LEN = 4;
  localparam int BEAT_W = 2;
  localparam int NUM_SLOTS = 2;        // two write buffers, two read slots

  // =====================================================================
  // read latency, counted in output-timing rising edges after the command
  // =====================================================================
  localparam int RD_START_DLL = 3;     // first beat 1.5 cycles after command
  localparam int RD_START_BYPASS = 2;  // first beat one cycle after command

  // =====================================================================
  // timing counts
  // =====================================================================
  localparam int DLL_LOCK_KCYC = 2048; // strobe cycles until the loop is locked
  localparam int TIE_DETECT_CYC = 16;  // core cycles of steady high output pair

  // =====================================================================
  // register map (byte addresses, 32-bit words)
  // =====================================================================
  localparam int WB_AW = 4;
  localparam int WB_DW = 32;
  localparam logic [WB_AW-1:0] CTRL_OFS = 4'h0;
  localparam logic [WB_AW-1:0] STATUS_OFS = 4'h4;
  localparam int CTRL_NARROW_BIT = 0;
  localparam logic CTRL_NARROW_RST = 1'b0;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_TIED_BIT = 1;
  localparam int STAT_BYPASS_BIT = 2;
  localparam int STAT_RDBUSY_BIT = 3;
  localparam int STAT_WRBUF_BIT = 4;

endpackage

// *** hw/pin_sync.sv ***
// =====================================================================
// pin_sync: two-flop synchroniser for a group of pins
// =====================================================================
// assumes: pins are static or change far slower than core_clk;
// a multi-bit group is only read once it has stood still a while
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins and synchronised copy
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] stable_ff;

  // =====================================================================
  // two stages; only the second stage is visible outside
  // =====================================================================
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      stable_ff <= RST_VAL;
    end else begin
      meta_ff <= pinIn;
      stable_ff <= meta_ff;
    end
  end

  assign pinOut = stable_ff;

endmodule

// *** hw/wb_reg_slave.sv ***
// =====================================================================
// wb_reg_slave: classic wishbone slave with a control and a status word
// =====================================================================
// assumes: master holds its request until it sees ack; same clock
module wb_reg_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sram_port_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [sram_port_pkg::WB_DW-1:0] wb_dat_i,
  output logic [sram_port_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // block side
  output logic ctrlNarrow,
  input wire logic [sram_port_pkg::WB_DW-1:0] statusWord
);

  logic ack_ff;
  logic narrow_ff;
  logic [sram_port_pkg::WB_DW-1:0] rdData_ff;
  logic newReq;
  logic [sram_port_pkg::WB_DW-1:0] ctrlWord;

  // a new request is one that has not yet been answered
  assign newReq = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdData_ff;
  assign ctrlNarrow = narrow_ff;

  always_comb begin
    ctrlWord = '0;
    ctrlWord[sram_port_pkg::CTRL_NARROW_BIT] = narrow_ff;
  end

  // =====================================================================
  // ack one cycle after the request, dropped the cycle after
  // =====================================================================
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= newReq;
    end
  end

  // read data latched with the ack; unmapped words read as zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= '0;
    end else if (newReq) begin
      unique case (wb_adr_i)
        sram_port_pkg::CTRL_OFS: rdData_ff <= ctrlWord;
        sram_port_pkg::STATUS_OFS: rdData_ff <= statusWord;
        default: rdData_ff <= '0;
      endcase
    end
  end

  // writes land on the edge where the master samples ack
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      narrow_ff <= sram_port_pkg::CTRL_NARROW_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0] &&
                 wb_adr_i == sram_port_pkg::CTRL_OFS) begin
      narrow_ff <= wb_dat_i[sram_port_pkg::CTRL_NARROW_BIT];
    end
  end

endmodule

// *** hw/ddr_burst4_cio_sram_port.sv ***
// =====================================================================
// ddr_burst4_cio_sram_port: memory-side pin logic of a double-data-rate
// burst-of-four common-I/O static memory, oversampled by core_clk
// =====================================================================
// assumes: strobes run far below core_clk (several samples per phase);
// the bench joins data pins from dataPinsOut/dataPinsOe
// Function
// - address and control are taken only on rising true input strobe
// - write data is taken on rising edges of both input strobes
// - read data timed by output pair, or by input pair when pair tied high
// - echo strobes run free, follow output timing, toggle while data floats
// - low bypass input drops lock; high starts lock after the lock time
// - bypass mode gives one-cycle read latency; controller keeps strobes slow
// - address ignored whenever no new cycle is loaded
// - data pins driven only while a read burst is out, else floating
// - narrow mode uses low eighteen lines; wide mode uses all lines
// - loaded cycle with direction high reads, direction low writes
// - each byte mask sampled with its beat; low mask writes that byte
// - bursts of four; a command edge is followed by one busy edge
// - bypass input high (loop in use): first read beat 1.5 cycles after command
// - two write buffers forward data to reads of recent write addresses
module ddr_burst4_cio_sram_port #(
  parameter int DATA_W = sram_port_pkg::DATA_W,
  parameter int BYTE_W = sram_port_pkg::BYTE_W,
  parameter int ADDR_W = sram_port_pkg::ADDR_W,
  parameter int ARRAY_AW = sram_port_pkg::ARRAY_AW
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // wishbone register port
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sram_port_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [sram_port_pkg::WB_DW-1:0] wb_dat_i,
  output logic [sram_port_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // strobes and timing pins
  input wire logic inputStrobeTrue,
  input wire logic inputStrobeComp,
  input wire logic outputTimingTrue,
  input wire logic outputTimingInv,
  input wire logic dllBypassN,
  // command pins
  input wire logic [ADDR_W-1:0] addrInputs,
  input wire logic cycleDefineN,
  input wire logic dirSel,
  input wire logic [DATA_W/BYTE_W-1:0] byteWriteMaskN,
  // data pins, split into three signals
  input wire logic [DATA_W-1:0] dataPinsIn,
  output logic [DATA_W-1:0] dataPinsOut,
  output logic [DATA_W-1:0] dataPinsOe,
  // echo strobes
  output logic echoStrobeTrue,
  output logic echoStrobeInv
);

  localparam int NBYTES = DATA_W / BYTE_W;
  localparam int NS = sram_port_pkg::NUM_SLOTS;
  localparam int BL = sram_port_pkg::BURST_LEN;
  localparam int BW = sram_port_pkg::BEAT_W;
  localparam logic [2:0] FILL_DONE = 3'(sram_port_pkg::BURST_LEN);
  localparam int TIE_W = $clog2(sram_port_pkg::TIE_DETECT_CYC + 1);
  localparam logic [TIE_W-1:0] TIE_MAX = TIE_W'(sram_port_pkg::TIE_DETECT_CYC);
  localparam int LOCK_W = $clog2(sram_port_pkg::DLL_LOCK_KCYC + 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(sram_port_pkg::DLL_LOCK_KCYC - 1);
  localparam int CMD_W = ADDR_W + 2;
  localparam int DIN_W = DATA_W + NBYTES;

  // =====================================================================
  // synchronisers: every pin passes two flops before use
  // =====================================================================
  logic [3:0] clkS;
  logic dllS;
  logic [CMD_W-1:0] cmdS;
  logic [DIN_W-1:0] dinS;

  pin_sync #(.W(4), .RST_VAL(4'h0)) clkSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn({outputTimingInv, outputTimingTrue, inputStrobeComp, inputStrobeTrue}),
    .pinOut(clkS)
  );

  pin_sync #(.W(1), .RST_VAL(1'b0)) dllSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(dllBypassN),
    .pinOut(dllS)
  );

  pin_sync #(.W(CMD_W), .RST_VAL({1'b1, 1'b0, {ADDR_W{1'b0}}})) cmdSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn({cycleDefineN, dirSel, addrInputs}),
    .pinOut(cmdS)
  );

  pin_sync #(.W(DIN_W), .RST_VAL({{NBYTES{1'b1}}, {DATA_W{1'b0}}})) dinSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn({byteWriteMaskN, dataPinsIn}),
    .pinOut(dinS)
  );

  // =====================================================================
  // edge detection on the synchronised strobes
  // =====================================================================
  logic [3:0] clkD_ff;
  logic kRise, kCompRise, oTrueRise, oCompRise, oEdge, cTied, bypass;
  logic [ADDR_W-1:0] cmdAddr;
  logic cmdDefineN, cmdRead;
  logic [DATA_W-1:0] dS;
  logic [NBYTES-1:0] maskS;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkD_ff <= 4'h0;
    end else begin
      clkD_ff <= clkS;
    end
  end

  assign kRise = clkS[0] & ~clkD_ff[0];
  assign kCompRise = clkS[1] & ~clkD_ff[1];
  assign {cmdDefineN, cmdRead, cmdAddr} = cmdS;
  assign {maskS, dS} = dinS;
  assign bypass = ~dllS;

  // output pair held high and still: the input pair times the outputs
  logic [TIE_W-1:0] tieCnt_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tieCnt_ff <= '0;
    end else if (clkS[3:2] != 2'b11 || clkS[3:2] != clkD_ff[3:2]) begin
      tieCnt_ff <= '0;
    end else if (tieCnt_ff != TIE_MAX) begin
      tieCnt_ff <= tieCnt_ff + 1'b1;
    end
  end

  assign cTied = (tieCnt_ff == TIE_MAX);
  assign oTrueRise = cTied ? kRise : (clkS[2] & ~clkD_ff[2]);
  assign oCompRise = cTied ? kCompRise : (clkS[3] & ~clkD_ff[3]);
  assign oEdge = oTrueRise | oCompRise;

  // =====================================================================
  // delay-locked loop model: only lock state, counted in strobe cycles
  // =====================================================================
  logic [LOCK_W-1:0] lockCnt_ff;
  logic dllLocked_ff;

  // bypass discards lock; release restarts the full lock count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockCnt_ff <= '0;
      dllLocked_ff <= 1'b0;
    end else if (bypass) begin
      lockCnt_ff <= '0;
      dllLocked_ff <= 1'b0;
    end else if (kRise && !dllLocked_ff) begin
      lockCnt_ff <= lockCnt_ff + 1'b1;
      dllLocked_ff <= (lockCnt_ff == LOCK_LAST);
    end
  end

  // =====================================================================
  // command decode on the rising true input strobe
  // =====================================================================
  logic busy_ff;
  logic accept, acceptRd, acceptWr;

  // address is looked at only when a cycle is loaded
  assign accept = kRise & ~cmdDefineN & ~busy_ff;
  assign acceptRd = accept & cmdRead;
  assign acceptWr = accept & ~cmdRead;

  // a burst holds the port for two cycles; the next edge is skipped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else if (kRise) begin
      busy_ff <= accept;
    end
  end

  // =====================================================================
  // lane masks: narrow mode disables the upper lanes
  // =====================================================================
  logic narrow;
  logic [NBYTES-1:0] laneOn;
  logic [DATA_W-1:0] pinOn;
  logic [NBYTES-1:0] beatBe;

  for (genvar y = 0; y < NBYTES; y++) begin : gLane
    assign laneOn[y] = ~narrow | ((y + 1) * BYTE_W <= sram_port_pkg::NARROW_W);
    assign pinOn[y*BYTE_W +: BYTE_W] = {BYTE_W{laneOn[y]}};
    assign beatBe[y] = ~maskS[y] & laneOn[y];
  end

  // =====================================================================
  // write buffers: two bursts held until the slot is reused
  // =====================================================================
  logic allocSlot_ff;
  logic [NS-1:0] bufValid_ff;
  logic [ADDR_W-1:0] bufAddr_ff [NS];
  logic [2:0] bufFill_ff [NS];
  logic [DATA_W-1:0] bufData_ff [NS][BL];
  logic [NBYTES-1:0] bufBe_ff [NS][BL];
  logic [DATA_W-1:0] mem_ff [2**ARRAY_AW];

  // the slot written next always holds the older burst
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      allocSlot_ff <= 1'b0;
    end else if (acceptWr) begin
      allocSlot_ff <= ~allocSlot_ff;
    end
  end

  // beats alternate true and complement rises after the command
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bufValid_ff <= '0;
      bufAddr_ff <= '{default: '0};
      bufFill_ff <= '{default: FILL_DONE};
      bufData_ff <= '{default: '{default: '0}};
      bufBe_ff <= '{default: '{default: '0}};
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (acceptWr && allocSlot_ff == 1'(s)) begin
          bufValid_ff[s] <= 1'b1;
          bufAddr_ff[s] <= cmdAddr;
          bufFill_ff[s] <= 3'd0;
          for (int b = 0; b < BL; b++) begin
            bufBe_ff[s][b] <= '0;
          end
        end else if (bufValid_ff[s] && bufFill_ff[s] != FILL_DONE &&
                     (bufFill_ff[s][0] ? kCompRise : kRise)) begin
          bufData_ff[s][bufFill_ff[s][BW-1:0]] <= dS;
          bufBe_ff[s][bufFill_ff[s][BW-1:0]] <= beatBe;
          bufFill_ff[s] <= bufFill_ff[s] + 3'd1;
        end
      end
    end
  end

  // the older burst reaches the array when its slot is reused;
  // an empty slot never wrote, whatever the mask lines did
  always_ff @(posedge core_clk) begin
    if (acceptWr && bufValid_ff[allocSlot_ff]) begin
      for (int b = 0; b < BL; b++) begin
        for (int y = 0; y < NBYTES; y++) begin
          if (bufBe_ff[allocSlot_ff][b][y]) begin
            mem_ff[{bufAddr_ff[allocSlot_ff][ARRAY_AW-BW-1:0], BW'(b)}][y*BYTE_W +: BYTE_W]
              <= bufData_ff[allocSlot_ff][b][y*BYTE_W +: BYTE_W];
          end
        end
      end
    end
  end

  // array word overlaid by the older then the newer buffer
  function automatic logic [DATA_W-1:0] fetch(input logic [ADDR_W-1:0] a,
                                              input logic [BW-1:0] beat);
    logic [DATA_W-1:0] w;
    logic s;
    w = mem_ff[{a[ARRAY_AW-BW-1:0], beat}];
    for (int k = 0; k < NS; k++) begin
      s = (k == 0) ? allocSlot_ff : ~allocSlot_ff;
      if (bufValid_ff[s] && bufAddr_ff[s] == a) begin
        for (int y = 0; y < NBYTES; y++) begin
          if (bufBe_ff[s][beat][y]) begin
            w[y*BYTE_W +: BYTE_W] = bufData_ff[s][beat][y*BYTE_W +: BYTE_W];
          end
        end
      end
    end
    return w;
  endfunction

  // =====================================================================
  // read slots: two, so a new read can start while one drains
  // =====================================================================
  logic rdAlloc_ff;
  logic [NS-1:0] rdValid_ff;
  logic [ADDR_W-1:0] rdAddr_ff [NS];
  logic [2:0] rdCnt_ff [NS];
  logic [2:0] rdStart;

  // bypass gives the one-cycle latency, otherwise 1.5 cycles
  assign rdStart = bypass ? 3'(sram_port_pkg::RD_START_BYPASS)
                          : 3'(sram_port_pkg::RD_START_DLL);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdAlloc_ff <= 1'b0;
    end else if (acceptRd) begin
      rdAlloc_ff <= ~rdAlloc_ff;
    end
  end

  // each slot counts output-timing rises; done after the fourth beat
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid_ff <= '0;
      rdAddr_ff <= '{default: '0};
      rdCnt_ff <= '{default: '0};
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (acceptRd && rdAlloc_ff == 1'(s)) begin
          rdValid_ff[s] <= 1'b1;
          rdAddr_ff[s] <= cmdAddr;
          rdCnt_ff[s] <= 3'd0;
        end else if (rdValid_ff[s] && oEdge) begin
          rdCnt_ff[s] <= rdCnt_ff[s] + 3'd1;
          if (rdCnt_ff[s] + 3'd1 == rdStart + 3'd3) begin
            rdValid_ff[s] <= 1'b0;
          end
        end
      end
    end
  end

  // pick the slot whose next timing rise falls inside its beat window
  logic hit;
  logic [ADDR_W-1:0] hitAddr;
  logic [BW-1:0] hitBeat;
  logic [2:0] nxt_cnt;

  always_comb begin
    hit = 1'b0;
    hitAddr = '0;
    hitBeat = '0;
    nxt_cnt = '0;
    for (int s = 0; s < NS; s++) begin
      nxt_cnt = rdCnt_ff[s] + 3'd1;
      if (rdValid_ff[s] && nxt_cnt >= rdStart && nxt_cnt <= rdStart + 3'd3) begin
        hit = 1'b1;
        hitAddr = rdAddr_ff[s];
        hitBeat = BW'(nxt_cnt - rdStart);
      end
    end
  end

  // =====================================================================
  // data and echo outputs; data updated on output-timing rises only, echoes every core cycle
  // =====================================================================
  logic [DATA_W-1:0] dqOut_ff;
  logic [DATA_W-1:0] dqOe_ff;
  logic echoTrue_ff, echoInv_ff;

  // pins drive only while a beat is out, and float afterwards
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dqOut_ff <= '0;
      dqOe_ff <= '0;
    end else if (oEdge) begin
      if (hit) begin
        dqOut_ff <= fetch(hitAddr, hitBeat) & pinOn;
      end
      dqOe_ff <= hit ? pinOn : '0;
    end
  end

  // echoes copy the timing pair with the data's delay, always running
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      echoTrue_ff <= 1'b0;
      echoInv_ff <= 1'b0;
    end else begin
      echoTrue_ff <= cTied ? clkS[0] : clkS[2];
      echoInv_ff <= cTied ? clkS[1] : clkS[3];
    end
  end

  assign dataPinsOut = dqOut_ff;
  assign dataPinsOe = dqOe_ff;
  assign echoStrobeTrue = echoTrue_ff;
  assign echoStrobeInv = echoInv_ff;

  // =====================================================================
  // register port
  // =====================================================================
  logic [sram_port_pkg::WB_DW-1:0] statusWord;

  always_comb begin
    statusWord = '0;
    statusWord[sram_port_pkg::STAT_LOCK_BIT] = dllLocked_ff;
    statusWord[sram_port_pkg::STAT_TIED_BIT] = cTied;
    statusWord[sram_port_pkg::STAT_BYPASS_BIT] = bypass;
    statusWord[sram_port_pkg::STAT_RDBUSY_BIT] = |rdValid_ff;
    statusWord[sram_port_pkg::STAT_WRBUF_BIT] = |bufValid_ff;
  end

  wb_reg_slave regs (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .ctrlNarrow(narrow),
    .statusWord(statusWord)
  );

endmodule

// *** tb/sram_ctl_model.sv ***
// =====================================================================
// sram_ctl_model: controller side of the memory port, strobes and pins
// assumes: bursts are queued whole, six half-cycle slots, command first
module sram_ctl_model (
  // clock
  input wire logic core_clk,
  // strobe pair
  output logic strobeTrue,
  output logic strobeComp,
  // command, mask and write data pins
  output logic [16:0] addrPins,
  output logic cycDefN,
  output logic dirPin,
  output logic [3:0] maskN,
  output logic [35:0] dataDrive
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] phase = 3'h0;
  logic [58:0] q[$];
  logic [58:0] slot;
  time cmdAt = 0;
  assign strobeTrue = phase[2];
  assign strobeComp = ~phase[2]; // half a period from the true strobe
  initial {cycDefN, dirPin, addrPins, maskN, dataDrive} = {2'b10, 57'h0};
  // pins move two core cycles before the rise they serve, so they stand on both sides of it
  always @(posedge core_clk) begin
    phase <= phase + 3'h1;
    if (phase[1:0] == 2'h1) begin
      slot = {2'b10, ~addrPins, 4'h0, ~dataDrive}; // idle: junk address, released data toggles
      if (q.size() > 0 && (!phase[2] || q.size() % 2 == 1)) slot = q.pop_front();
      {cycDefN, dirPin, addrPins, maskN, dataDrive} <= slot; // command pins move together
      if (!phase[2] && !slot[58]) cmdAt <= $time + 50;
    end
  end
endmodule

// *** tb/sram_port_assertions.sv ***
// =====================================================================
// sram_port_checker: handshake, data pin drive and echo checks
// assumes: bound to the port's top module, one core_clk domain
module sram_port_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // wishbone handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // memory pins
  input wire logic [35:0] dataPinsOut,
  input wire logic [35:0] dataPinsOe,
  input wire logic echoStrobeTrue
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] quietCnt;
  // cycles since the echo moved; saturates so a stall never wraps back to legal
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      quietCnt <= 6'h0;
    else if ($changed(echoStrobeTrue))
      quietCnt <= 6'h0;
    else if (quietCnt != 6'h3f)
      quietCnt <= quietCnt + 6'h1;
  end
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
  oe_shape_a: assert property (dataPinsOe inside {36'h0, 36'h3_FFFF, 36'hF_FFFF_FFFF})
    else $error("bad enables");
  burst_len_a: assert property ($rose(dataPinsOe[0]) |-> dataPinsOe[0] [*8])
    else $error("short burst");
  burst_gap_a: assert property ($fell(dataPinsOe[0]) |=> !dataPinsOe[0] [*3])
    else $error("burst restarts");
  beat_hold_a: assert property (dataPinsOe[0] && $changed(dataPinsOut) |=> $stable(dataPinsOut) [*2])
    else $error("beat too short");
  echo_runs_a: assert property (quietCnt < 6'h28) else $error("echo stalled");
endmodule
bind ddr_burst4_cio_sram_port sram_port_checker u_chk (.core_clk, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .dataPinsOut, .dataPinsOe, .echoStrobeTrue);

// *** tb/testbench.sv ***
// =====================================================================
// testbench: memory port fed by the controller model, registers over wishbone
// assumes: output timing pair tied high; a strobe period is eight core cycles
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, dllOn = 1'b1, sT, sC, cdn, dir;
  logic [3:0] adr = 4'h0, mask;
  logic [31:0] wdat = 32'h0, rdat;
  logic [16:0] addr;
  logic [35:0] drv, dOut, dOe, pinsIn, prevOe = 36'h0, prevOut, oeSeen, beats[$];
  time riseAt, lat, latOn;
  int nErrors = 0, numChecks = 0;
  assign pinsIn = (dOe & dOut) | (~dOe & drv); // device wins while it drives
  initial forever #12.5 core_clk = ~core_clk;
  ddr_burst4_cio_sram_port u_dut (.core_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .inputStrobeTrue(sT), .inputStrobeComp(sC), .outputTimingTrue(1'b1),
    .outputTimingInv(1'b1), .dllBypassN(dllOn), .addrInputs(addr), .cycleDefineN(cdn),
    .dirSel(dir), .byteWriteMaskN(mask), .dataPinsIn(pinsIn), .dataPinsOut(dOut),
    .dataPinsOe(dOe), .echoStrobeTrue(), .echoStrobeInv());
  sram_ctl_model u_ctl (.core_clk, .strobeTrue(sT), .strobeComp(sC), .addrPins(addr),
    .cycDefN(cdn), .dirPin(dir), .maskN(mask), .dataDrive(drv));
  // a beat is a new value on driven pins, so queued test data never repeats
  always @(posedge core_clk) begin
    if (dOe !== 36'h0 && (prevOe === 36'h0 || dOut !== prevOut))
      beats.push_back(dOut & dOe);
    if (dOe !== 36'h0 && prevOe === 36'h0) begin
      riseAt = $time;
      oeSeen = dOe;
    end
    prevOe = dOe;
    prevOut = dOut;
  end
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  // command half, quiet half, four data halves; a write hides a read on the next edge
  task automatic burst(input logic rd, input logic [16:0] a, input logic [3:0] m,
                       input logic [35:0] d);
    u_ctl.q.push_back({1'b0, rd, a, 4'hF, ~d});
    u_ctl.q.push_back({2'b10, ~a, 4'h0, ~d});
    for (int b = 0; b < 4; b++)
      u_ctl.q.push_back({b != 0 || rd, 1'b1, ~a, m, d + 36'(b)});
    wait (u_ctl.q.size() == 0);
    repeat (40) @(posedge core_clk);
  endtask
  // read a burst; d1 overlays d0 on the bytes that mask m1 let through
  task automatic rdBack(input logic [16:0] a, input logic [35:0] d0, input logic [35:0] d1,
                        input logic [3:0] m1, input logic [35:0] keep);
    logic [35:0] bm, e;
    for (int i = 0; i < 4; i++)
      bm[i*9 +: 9] = {9{~m1[i]}};
    burst(1'b1, a, 4'h0, 36'h0);
    lat = riseAt - u_ctl.cmdAt;
    chk(36'(beats.size()), 36'h4);
    for (int b = 0; b < 4; b++) begin
      e = ((d1 + 36'(b)) & bm) | ((d0 + 36'(b)) & ~bm);
      chk(beats[b], e & keep);
    end
    beats.delete();
  endtask
  task automatic summarize();
    if (nErrors == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // the run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    wb(1'b1, 4'hC, 32'h1);
    wb(1'b0, sram_port_pkg::CTRL_OFS, 32'h0);
    chk(36'(rdat), 36'h0);
    wb(1'b0, 4'h8, 32'h0);
    chk(36'(rdat), 36'h0);
    repeat (30) @(posedge core_clk);
    wb(1'b0, sram_port_pkg::STATUS_OFS, 32'h0);
    chk(36'(rdat), 36'h2);
    burst(1'b0, 17'h5, 4'h0, 36'h1_1111_1110);
    rdBack(17'h5, 36'h1_1111_1110, 36'h1_1111_1110, 4'h0, 36'hF_FFFF_FFFF);
    latOn = lat;
    chk(36'(latOn >= 300 && latOn <= 425), 36'h1);
    burst(1'b0, 17'h5, 4'b0101, 36'h2_2222_2220);
    rdBack(17'h5, 36'h1_1111_1110, 36'h2_2222_2220, 4'b0101, 36'hF_FFFF_FFFF);
    burst(1'b0, 17'h9, 4'h0, 36'h3_3333_3330);
    burst(1'b0, 17'hC, 4'h0, 36'h4_4444_4440);
    rdBack(17'h5, 36'h1_1111_1110, 36'h2_2222_2220, 4'b0101, 36'hF_FFFF_FFFF);
    dllOn <= 1'b0;
    repeat (4) @(posedge core_clk);
    wb(1'b0, sram_port_pkg::STATUS_OFS, 32'h0);
    chk(36'(rdat), 36'h16);
    rdBack(17'h9, 36'h3_3333_3330, 36'h3_3333_3330, 4'h0, 36'hF_FFFF_FFFF);
    chk(36'(latOn - lat), 36'h64);
    wb(1'b1, sram_port_pkg::CTRL_OFS, 32'h1);
    wb(1'b0, sram_port_pkg::CTRL_OFS, 32'h0);
    chk(36'(rdat), 36'h1);
    rdBack(17'hC, 36'h4_4444_4440, 36'h4_4444_4440, 4'h0, 36'h0_0003_FFFF);
    chk(oeSeen, 36'h0_0003_FFFF);
    summarize();
  end
endmodule
